// >>> rtl/hdcg_regs.vh
`ifndef HDCG_REGS_VH
`define HDCG_REGS_VH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define HDCG_ADDR_CFG 8'h00
`define HDCG_ADDR_STATUS 8'h04

// ----------------------------------------
// Config register fields
// ----------------------------------------
`define HDCG_CFG_BUS_MASK_LSB 0
`define HDCG_CFG_SELF_MASK_LSB 4
`define HDCG_CFG_PWR_MODE_BIT 8
`define HDCG_CFG_PORT_SW_BIT 9
`define HDCG_CFG_COMPOUND_BIT 10
`define HDCG_CFG_OC_SENSE_LSB 11
`define HDCG_CFG_MULTI_TT_BIT 16
`define HDCG_CFG_RESET 32'h0001_0000

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define HDCG_STS_PORTS_LSB 0
`define HDCG_STS_CHAR_LSB 8
`define HDCG_STS_BUSY_BIT 24

// ----------------------------------------
// Descriptor constants
// ----------------------------------------
`define HDCG_TYPE_IFACE 8'h04
`define HDCG_TYPE_EP 8'h05
`define HDCG_TYPE_HUB 8'h29
`define HDCG_TYPE_HUB_OLD 8'h00
`define HDCG_IFACE_LEN 8'h09
`define HDCG_IFACE_NUM 8'h00
`define HDCG_IFACE_ALT 8'h01
`define HDCG_IFACE_NEP 8'h01
`define HDCG_IFACE_CLASS 8'h09
`define HDCG_IFACE_SUB 8'h00
`define HDCG_IFACE_PROTO 8'h02
`define HDCG_IFACE_STR 8'h00
`define HDCG_EP_LEN 8'h07
`define HDCG_EP_ADDR 8'h81
`define HDCG_EP_ATTR 8'h03
`define HDCG_EP_MPS 16'h0001
`define HDCG_EP_MPS_LO 8'h01
`define HDCG_EP_MPS_HI 8'h00
`define HDCG_EP_INTERVAL 8'h0C
`define HDCG_HUB_LEN 8'h09
`define HDCG_HUB_BYTES 8'h05
`define HDCG_TOTAL_PORTS 3
`define HDCG_THINK_TIME 2'h0

`endif

// >>> rtl/hdcg_desc_gen.v
`timescale 1ns/1ps
`include "hdcg_regs.vh"

module hdcg_desc_gen #(
  parameter NUM_PORTS = `HDCG_TOTAL_PORTS
) (
  input wire core_clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire req_valid,
  input wire [7:0] req_type,
  input wire [7:0] req_length,
  output reg req_busy,
  output reg req_stall,
  output reg desc_valid,
  output reg [7:0] desc_data,
  output reg desc_last,
  output reg desc_done
);

  // ----------------------------------------
  // Local definitions
  // ----------------------------------------
  localparam [1:0] KIND_IFACE = 2'h0;
  localparam [1:0] KIND_EP = 2'h1;
  localparam [1:0] KIND_HUB = 2'h2;

  localparam [0:0] ST_IDLE = 1'b0;
  localparam [0:0] ST_SEND = 1'b1;

  reg [31:0] cfg;
  reg [0:0] state;
  reg [1:0] kind;
  reg [7:0] idx;
  reg [7:0] count;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function [7:0] ones;
    input [NUM_PORTS-1:0] mask;
    integer i;
    begin
      ones = 8'h00;
      for (i = 0; i < NUM_PORTS; i = i + 1) begin
        ones = ones + {7'h00, mask[i]};
      end
    end
  endfunction

  function [7:0] min8;
    input [7:0] a;
    input [7:0] b;
    begin
      min8 = (a < b) ? a : b;
    end
  endfunction

  // Shared by the write path and both read paths
  function addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_hit = (addr == target);
    end
  endfunction

  // Hub descriptor bytes beyond offset 4 come from another block
  function [7:0] kind_size;
    input [1:0] k;
    begin
      case (k)
        KIND_IFACE: kind_size = `HDCG_IFACE_LEN;
        KIND_EP: kind_size = `HDCG_EP_LEN;
        KIND_HUB: kind_size = `HDCG_HUB_BYTES;
        default: kind_size = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Configuration decode
  // ----------------------------------------
  wire power_mode_select = cfg[`HDCG_CFG_PWR_MODE_BIT];
  wire per_port_switching_select = cfg[`HDCG_CFG_PORT_SW_BIT];
  wire compound_device = cfg[`HDCG_CFG_COMPOUND_BIT];
  wire [1:0] overcurrent_sense_field = cfg[`HDCG_CFG_OC_SENSE_LSB +: 2];
  wire multi_tt_enable = cfg[`HDCG_CFG_MULTI_TT_BIT];
  wire [NUM_PORTS-1:0] bus_pwr_disabled_port_mask = cfg[`HDCG_CFG_BUS_MASK_LSB +: NUM_PORTS];
  wire [NUM_PORTS-1:0] self_pwr_disabled_port_mask =
    cfg[`HDCG_CFG_SELF_MASK_LSB +: NUM_PORTS];

  // Mask follows the live power mode, so a mode change shows at once
  wire [NUM_PORTS-1:0] active_mask = power_mode_select ?
    self_pwr_disabled_port_mask : bus_pwr_disabled_port_mask;

  // Cut on purpose: the count byte holds at most 255 ports
  localparam [31:0] NUM_PORTS_W = NUM_PORTS;
  wire [7:0] total_ports = NUM_PORTS_W[7:0];
  wire [7:0] port_count = total_ports - ones(active_mask);

  wire [15:0] hub_char;
  assign hub_char[1:0] = {1'b0, per_port_switching_select};
  assign hub_char[2] = compound_device;
  assign hub_char[4:3] = overcurrent_sense_field;
  assign hub_char[6:5] = `HDCG_THINK_TIME;
  assign hub_char[7] = 1'b0;
  assign hub_char[15:8] = 8'h00;

  // ----------------------------------------
  // Descriptor byte table
  // ----------------------------------------
  reg [7:0] table_byte;

  always @* begin
    table_byte = 8'h00;
    case (kind)
      KIND_IFACE: begin
        case (idx)
          8'h00: table_byte = `HDCG_IFACE_LEN;
          8'h01: table_byte = `HDCG_TYPE_IFACE;
          8'h02: table_byte = `HDCG_IFACE_NUM;
          8'h03: table_byte = `HDCG_IFACE_ALT;
          8'h04: table_byte = `HDCG_IFACE_NEP;
          8'h05: table_byte = `HDCG_IFACE_CLASS;
          8'h06: table_byte = `HDCG_IFACE_SUB;
          8'h07: table_byte = `HDCG_IFACE_PROTO;
          8'h08: table_byte = `HDCG_IFACE_STR;
          default: table_byte = 8'h00;
        endcase
      end
      KIND_EP: begin
        case (idx)
          8'h00: table_byte = `HDCG_EP_LEN;
          8'h01: table_byte = `HDCG_TYPE_EP;
          8'h02: table_byte = `HDCG_EP_ADDR;
          8'h03: table_byte = `HDCG_EP_ATTR;
          8'h04: table_byte = `HDCG_EP_MPS_LO;
          8'h05: table_byte = `HDCG_EP_MPS_HI;
          8'h06: table_byte = `HDCG_EP_INTERVAL;
          default: table_byte = 8'h00;
        endcase
      end
      KIND_HUB: begin
        case (idx)
          8'h00: table_byte = `HDCG_HUB_LEN;
          8'h01: table_byte = `HDCG_TYPE_HUB;
          8'h02: table_byte = port_count;
          8'h03: table_byte = hub_char[7:0];
          8'h04: table_byte = hub_char[15:8];
          default: table_byte = 8'h00;
        endcase
      end
      default: table_byte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  reg req_known;
  reg [1:0] req_kind;

  always @* begin
    req_known = 1'b0;
    req_kind = KIND_HUB;
    case (req_type)
      `HDCG_TYPE_IFACE: begin
        req_known = multi_tt_enable;
        req_kind = KIND_IFACE;
      end
      `HDCG_TYPE_EP: begin
        req_known = multi_tt_enable;
        req_kind = KIND_EP;
      end
      `HDCG_TYPE_HUB, `HDCG_TYPE_HUB_OLD: begin
        req_known = 1'b1;
        req_kind = KIND_HUB;
      end
      default: begin
        req_known = 1'b0;
        req_kind = KIND_HUB;
      end
    endcase
  end

  wire [7:0] req_count = min8(req_length, kind_size(req_kind));

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  reg [0:0] next_state;
  reg [1:0] next_kind;
  reg [7:0] next_idx;
  reg [7:0] next_count;
  reg next_valid;
  reg next_last;
  reg next_done;
  reg next_stall;

  always @* begin
    next_state = state;
    next_kind = kind;
    next_idx = idx;
    next_count = count;
    next_valid = 1'b0;
    next_last = 1'b0;
    next_done = 1'b0;
    next_stall = 1'b0;
    case (state)
      ST_IDLE: begin
        if (req_valid) begin
          if (!req_known) begin
            next_stall = 1'b1;
            next_done = 1'b1;
          end else if (req_count == 8'h00) begin
            next_done = 1'b1;
          end else begin
            next_state = ST_SEND;
            next_kind = req_kind;
            next_idx = 8'h00;
            next_count = req_count;
          end
        end
      end
      ST_SEND: begin
        // Bytes leave in ascending offset order
        next_valid = 1'b1;
        next_idx = idx + 8'h01;
        if (idx == count - 8'h01) begin
          next_last = 1'b1;
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      kind <= KIND_IFACE;
      idx <= 8'h00;
      count <= 8'h00;
      desc_valid <= 1'b0;
      desc_data <= 8'h00;
      desc_last <= 1'b0;
      desc_done <= 1'b0;
      req_stall <= 1'b0;
      req_busy <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      idx <= next_idx;
      count <= next_count;
      desc_valid <= next_valid;
      desc_data <= next_valid ? table_byte : 8'h00;
      desc_last <= next_last;
      desc_done <= next_done;
      req_stall <= next_stall;
      // Busy covers the stream except its last byte; requests meanwhile are dropped
      req_busy <= (next_state == ST_SEND);
    end
  end

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  // Field positions live in the header so software and logic agree
  reg [31:0] status_word;

  always @* begin
    status_word = 32'h0000_0000;
    status_word[`HDCG_STS_PORTS_LSB +: 8] = port_count;
    status_word[`HDCG_STS_CHAR_LSB +: 16] = hub_char;
    status_word[`HDCG_STS_BUSY_BIT] = req_busy;
  end

  always @(posedge core_clk) begin
    if (reset) begin
      cfg <= `HDCG_CFG_RESET;
      reg_rdata <= 32'h0000_0000;
    end else begin
      if (reg_wr && addr_hit(reg_addr, `HDCG_ADDR_CFG)) begin
        cfg <= reg_wdata;
      end
      // Read data stands one cycle only; unmapped reads return zero
      if (reg_rd && addr_hit(reg_addr, `HDCG_ADDR_CFG)) begin
        reg_rdata <= cfg;
      end else if (reg_rd && addr_hit(reg_addr, `HDCG_ADDR_STATUS)) begin
        reg_rdata <= status_word;
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

endmodule // hdcg_desc_gen

// >>> test/hdcg_desc_gen_assertions.sv
`timescale 1ns/1ps
// ----------------
// Stream checks
// ----------------
module hdcg_checker #(
  parameter NUM_PORTS = 3
) (
  input wire core_clk,
  input wire reset,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  input wire req_valid,
  input wire [7:0] req_type,
  input wire [7:0] req_length,
  input wire req_busy,
  input wire req_stall,
  input wire desc_valid,
  input wire [7:0] desc_data,
  input wire desc_last,
  input wire desc_done
);
  wire take = req_valid && !req_busy;
  wire hub = take && (req_type == 8'h29 || req_type == 8'h00);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_hub_len;
    hub && req_length != 8'h00 |-> ##2 desc_valid && desc_data == 8'h09;
  endproperty
  a_hub_len: assert property (p_hub_len) else $error("hub length byte wrong");
  property p_hub_type;
    hub && req_length > 8'h01 |-> ##3 desc_data == 8'h29;
  endproperty
  a_hub_type: assert property (p_hub_type) else $error("hub type byte wrong");
  property p_ports;
    hub && req_length > 8'h02 |-> ##4 desc_data <= NUM_PORTS;
  endproperty
  a_ports: assert property (p_ports) else $error("port count too high");
  property p_char;
    hub && req_length > 8'h04 |-> ##5 desc_data[7:5] == 3'h0 ##1 desc_data == 8'h00 && desc_last;
  endproperty
  a_char: assert property (p_char) else $error("fixed characteristics bits wrong");
  property p_trunc;
    hub && req_length == 8'h01 |-> ##2 desc_valid && desc_last && desc_done;
  endproperty
  a_trunc: assert property (p_trunc) else $error("short request not cut");
  property p_iface;
    take && req_type == 8'h04 && req_length != 8'h00 |=>
      req_stall or ##1 (desc_valid && desc_data == 8'h09);
  endproperty
  a_iface: assert property (p_iface) else $error("interface length byte wrong");
  property p_ep;
    take && req_type == 8'h05 && req_length != 8'h00 |=>
      req_stall or ##1 (desc_valid && desc_data == 8'h07);
  endproperty
  a_ep: assert property (p_ep) else $error("endpoint length byte wrong");
  property p_unknown;
    take && !(req_type inside {8'h04, 8'h05, 8'h29, 8'h00}) |=> req_stall && desc_done;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown type not refused");
  property p_nogap;
    desc_valid && !desc_last |=> desc_valid;
  endproperty
  a_nogap: assert property (p_nogap) else $error("gap in byte stream");
  property p_busy;
    desc_valid |-> req_busy == !desc_last;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not covering stream");
  c_hub: cover property (hub);
  c_stall: cover property (req_stall);
  c_last: cover property (desc_last && desc_data == 8'h0C);
endmodule // hdcg_checker

bind hdcg_desc_gen hdcg_checker #(.NUM_PORTS(NUM_PORTS)) u_chk (
  .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
  .req_type(req_type), .req_length(req_length), .req_busy(req_busy),
  .req_stall(req_stall), .desc_valid(desc_valid), .desc_data(desc_data),
  .desc_last(desc_last), .desc_done(desc_done));

// >>> test/hdcg_host_model.sv
`timescale 1ns/1ps
// ----------------
// Host requester
// ----------------
module hdcg_host_model (
  input wire core_clk,
  output logic req_valid,
  output logic [7:0] req_type,
  output logic [7:0] req_length,
  input wire req_stall,
  input wire desc_valid,
  input wire [7:0] desc_data,
  input wire desc_done
);
  logic [7:0] rx [16];
  integer n;
  logic stalled;
  logic ok;
  initial begin
    req_valid = 1'b0;
    req_type = 8'hFF;
    req_length = 8'hFF;
  end
  // Call just after a rising edge; released lines show the inverse value
  task automatic get(input logic [7:0] t, input logic [7:0] l);
    integer i;
    begin
      n = 0;
      stalled = 1'b0;
      ok = 1'b0;
      req_valid <= 1'b1;
      req_type <= t;
      req_length <= l;
      @(posedge core_clk);
      req_valid <= 1'b0;
      req_type <= ~t;
      req_length <= ~l;
      for (i = 0; i < 40 && !ok; i++) begin
        @(posedge core_clk);
        if (desc_valid === 1'b1 && n < 16) begin
          rx[n] = desc_data;
          n++;
        end
        if (req_stall === 1'b1) stalled = 1'b1;
        if (desc_done === 1'b1) ok = 1'b1;
      end
    end
  endtask
endmodule // hdcg_host_model

// >>> test/hdcg_desc_gen_test.sv
`timescale 1ns/1ps
// ----------------
// Testbench
// ----------------
module hdcg_desc_gen_test;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] rd_val;
  wire [31:0] reg_rdata;
  wire req_valid, req_busy, req_stall, desc_valid, desc_last, desc_done;
  wire [7:0] req_type, req_length, desc_data;
  integer n_errors = 0;
  integer checks = 0;
  integer i;
  integer k;
  logic [7:0] ifd [9] = '{8'h09, 8'h04, 8'h00, 8'h01, 8'h01, 8'h09, 8'h00, 8'h02, 8'h00};
  logic [7:0] epd [7] = '{8'h07, 8'h05, 8'h81, 8'h03, 8'h01, 8'h00, 8'h0C};
  // Masks, power mode and characteristic inputs in varied mixes
  logic [31:0] cfg [5] = '{32'h0001_0000, 32'h0001_0005, 32'h0001_0125, 32'h0001_1E07,
    32'h0001_0A70};
  logic [7:0] ports [5] = '{8'h03, 8'h01, 8'h02, 8'h00, 8'h03};
  logic [7:0] chr [5] = '{8'h00, 8'h00, 8'h00, 8'h1D, 8'h09};
  hdcg_desc_gen u_dut (
    .core_clk(core_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req_valid(req_valid),
    .req_type(req_type), .req_length(req_length), .req_busy(req_busy),
    .req_stall(req_stall), .desc_valid(desc_valid), .desc_data(desc_data),
    .desc_last(desc_last), .desc_done(desc_done));
  hdcg_host_model u_host (
    .core_clk(core_clk), .req_valid(req_valid), .req_type(req_type),
    .req_length(req_length), .req_stall(req_stall), .desc_valid(desc_valid),
    .desc_data(desc_data), .desc_done(desc_done));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Extra edge after the strobe so back-to-back calls never reassign it at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    rd_val = reg_rdata;
  endtask
  task automatic req(input logic [7:0] t, input logic [7:0] l);
    u_host.get(t, l);
    chk("done", u_host.ok, 1);
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd(8'h00);
    chk("cfg", rd_val, 32'h0001_0000);
    rd(8'h08);
    chk("unmapped", rd_val, 32'h0);
    req(8'h04, 8'h09);
    chk("iface count", u_host.n, 9);
    for (i = 0; i < 9; i++) chk("iface", u_host.rx[i], ifd[i]);
    req(8'h05, 8'hFF);
    chk("ep count", u_host.n, 7);
    for (i = 0; i < 7; i++) chk("ep", u_host.rx[i], epd[i]);
    req(8'h05, 8'h03);
    chk("ep cut", u_host.n, 3);
    req(8'h29, 8'h01);
    chk("hub cut", u_host.n, 1);
    for (k = 0; k < 5; k++) begin
      wr(8'h00, cfg[k]);
      req(k[0] ? 8'h00 : 8'h29, 8'h40);
      chk("hub count", u_host.n, 5);
      chk("hub len", u_host.rx[0], 8'h09);
      chk("hub type", u_host.rx[1], 8'h29);
      chk("ports", u_host.rx[2], ports[k]);
      chk("char", {u_host.rx[4], u_host.rx[3]}, {8'h00, chr[k]});
      rd(8'h04);
      chk("status", rd_val, {8'h00, 8'h00, chr[k], ports[k]});
    end
    wr(8'h00, 32'h0);
    req(8'h04, 8'h09);
    chk("iface off", {u_host.stalled, u_host.n[7:0]}, 9'h100);
    req(8'h22, 8'h09);
    chk("unknown", {u_host.stalled, u_host.n[7:0]}, 9'h100);
    req(8'h29, 8'h00);
    chk("zero len", {u_host.stalled, u_host.n[7:0]}, 9'h000);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd(8'h00);
    chk("cfg after reset", rd_val, 32'h0001_0000);
    req(8'h04, 8'h01);
    chk("iface after reset", {u_host.n[7:0], u_host.rx[0]}, 16'h0109);
    tally_and_finish;
  end
endmodule // hdcg_desc_gen_test
